/* File: gpc_port.sv */
// Top of the GPIO port: APB registers, pad control and change interrupt
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module gpc_port
  import gpc_pkg::*;
#(
  parameter int W  = GPC_PINS,
  parameter int AW = GPC_AW
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic [W-1:0]  pad_st_in,
  input  wire logic [W-1:0]  pad_ttl_in,
  output logic      [W-1:0]  pad_out,
  output logic      [W-1:0]  pad_oe,
  output logic      [W-1:0]  pad_slew,
  output logic      [W-1:0]  pad_pullup,
  output logic      [W-1:0]  pad_analog,
  input  wire logic          sleep_active,
  output logic               change_irq,
  output logic               wake_req
);

  // Configuration and status registers
  logic [W-1:0]  latch_q;
  logic [W-1:0]  dir_q;
  logic [W-1:0]  analog_q;
  logic [W-1:0]  inlvl_q;
  logic [W-1:0]  odrain_q;
  logic [W-1:0]  slew_q;
  logic [W-1:0]  pullup_q;
  logic [W-1:0]  rise_q;
  logic [W-1:0]  fall_q;
  logic [W-1:0]  flag_q;
  logic [W-1:0]  flag_d;
  logic          ie_q;

  // Bus response registers
  logic [31:0]   prdata_q;
  logic          pready_q;
  logic          pslverr_q;

  // Pad and interrupt output registers
  logic [W-1:0]  pad_out_q;
  logic [W-1:0]  pad_oe_q;
  logic [W-1:0]  pad_slew_q;
  logic [W-1:0]  pad_pullup_q;
  logic [W-1:0]  pad_analog_q;
  logic          change_irq_q;
  logic          wake_req_q;

  // Bus decode
  logic          setup;
  logic          acc_wr;
  logic          lane0;
  logic          lane1;
  logic          addr_hit;
  logic [31:0]   rd_mux;
  logic [11:0]   ofs;
  logic          summary;
  logic          wr_pin;
  logic          wr_latch;
  logic          wr_dir;
  logic          wr_analog;
  logic          wr_inlvl;
  logic          wr_odrain;
  logic          wr_slew;
  logic          wr_pullup;
  logic          wr_rise;
  logic          wr_fall;
  logic          wr_flag;
  logic          wr_ictrl;

  // Pin sensing
  logic [W-1:0]  pin_level;
  logic [W-1:0]  edge_evt;
  logic [W-1:0]  pin_wmask;
  logic [W-1:0]  pin_wr_val;

  gpc_sense_if #(.W(W)) sense_if ();

  assign sense_if.thr_sel = inlvl_q;
  assign sense_if.analog  = analog_q;
  assign sense_if.rise_en = rise_q;
  assign sense_if.fall_en = fall_q;

  gpc_pin_sense #(
    .W (W)
  ) u_gpc_pin_sense (
    .clk     (pclk),
    .rst_n   (presetn),
    .pin_st  (pad_st_in),
    .pin_ttl (pad_ttl_in),
    .sn      (sense_if)
  );

  assign pin_level = sense_if.level;
  assign edge_evt  = sense_if.rise_evt | sense_if.fall_evt;
  assign summary   = |flag_q;

  // Address and phase decode
  assign ofs    = 12'(paddr);
  assign setup  = psel & ~penable;
  assign acc_wr = psel & penable & pready_q & pwrite;
  assign lane0  = pstrb[0];
  assign lane1  = pstrb[1];

  assign wr_pin    = acc_wr & lane0 & (ofs == GPC_OFS_PIN);
  assign wr_latch  = acc_wr & lane0 & (ofs == GPC_OFS_LATCH);
  assign wr_dir    = acc_wr & lane0 & (ofs == GPC_OFS_DIR);
  assign wr_analog = acc_wr & lane0 & (ofs == GPC_OFS_ANALOG);
  assign wr_inlvl  = acc_wr & lane0 & (ofs == GPC_OFS_INLVL);
  assign wr_odrain = acc_wr & lane0 & (ofs == GPC_OFS_ODRAIN);
  assign wr_slew   = acc_wr & lane0 & (ofs == GPC_OFS_SLEW);
  assign wr_pullup = acc_wr & lane0 & (ofs == GPC_OFS_PULLUP);
  assign wr_rise   = acc_wr & lane0 & (ofs == GPC_OFS_RISE);
  assign wr_fall   = acc_wr & lane0 & (ofs == GPC_OFS_FALL);
  assign wr_flag   = acc_wr & lane0 & (ofs == GPC_OFS_FLAG);
  assign wr_ictrl  = acc_wr & lane0 & (ofs == GPC_OFS_ICTRL);

  always_comb begin
    addr_hit = 1'b1;
    rd_mux   = 32'h0000_0000;
    case (ofs)
      GPC_OFS_PIN:    rd_mux[W-1:0] = pin_level;
      GPC_OFS_LATCH:  rd_mux[W-1:0] = latch_q;
      GPC_OFS_DIR:    rd_mux[W-1:0] = dir_q;
      GPC_OFS_ANALOG: rd_mux[W-1:0] = analog_q;
      GPC_OFS_INLVL:  rd_mux[W-1:0] = inlvl_q;
      GPC_OFS_ODRAIN: rd_mux[W-1:0] = odrain_q;
      GPC_OFS_SLEW:   rd_mux[W-1:0] = slew_q;
      GPC_OFS_PULLUP: rd_mux[W-1:0] = pullup_q;
      GPC_OFS_RISE:   rd_mux[W-1:0] = rise_q;
      GPC_OFS_FALL:   rd_mux[W-1:0] = fall_q;
      GPC_OFS_FLAG:   rd_mux[W-1:0] = flag_q;
      GPC_OFS_ICTRL: begin
        rd_mux[GPC_ICTRL_IE_BIT] = ie_q;
        rd_mux[GPC_ICTRL_IF_BIT] = summary;
      end
      default:        addr_hit = 1'b0;
    endcase
  end

  // Zero-wait-state APB answer, ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else if (setup) begin
      pslverr_q <= ~addr_hit;
    end else if (!psel) begin
      pslverr_q <= 1'b0;
    end
  end

  // Port write: sampled pins with the selected bits replaced
  always_comb begin
    pin_wmask  = lane1 ? pwdata[GPC_WMASK_LSB +: W] : {W{1'b1}};
    pin_wr_val = (pin_level & ~pin_wmask) | (pwdata[W-1:0] & pin_wmask);
  end

  // Output latch, written directly or through the port register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_q <= GPC_RST_LATCH;
    end else if (wr_pin) begin
      latch_q <= pin_wr_val;
    end else if (wr_latch) begin
      latch_q <= pwdata[W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q <= GPC_RST_DIR;
    end else if (wr_dir) begin
      dir_q <= pwdata[W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_q <= GPC_RST_ANALOG;
    end else if (wr_analog) begin
      analog_q <= pwdata[W-1:0];
    end
  end

  // A threshold change can itself look like an edge on the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inlvl_q <= GPC_RST_INLVL;
    end else if (wr_inlvl) begin
      inlvl_q <= pwdata[W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      odrain_q <= GPC_RST_ODRAIN;
    end else if (wr_odrain) begin
      odrain_q <= pwdata[W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slew_q <= GPC_RST_SLEW;
    end else if (wr_slew) begin
      slew_q <= pwdata[W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullup_q <= GPC_RST_PULLUP;
    end else if (wr_pullup) begin
      pullup_q <= pwdata[W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_q <= GPC_RST_RISE;
    end else if (wr_rise) begin
      rise_q <= pwdata[W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fall_q <= GPC_RST_FALL;
    end else if (wr_fall) begin
      fall_q <= pwdata[W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ie_q <= GPC_RST_IE;
    end else if (wr_ictrl) begin
      ie_q <= pwdata[GPC_ICTRL_IE_BIT];
    end
  end

  // Change flags: software clears by writing zeros, a new edge always wins
  always_comb begin
    flag_d = flag_q;
    if (wr_flag) begin
      flag_d = flag_q & pwdata[W-1:0];
    end
    flag_d = flag_d | edge_evt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= GPC_RST_FLAG;
    end else begin
      flag_q <= flag_d;
    end
  end

  // Interrupt and wake follow the stored flags, so flags lead by a cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      change_irq_q <= 1'b0;
    end else begin
      change_irq_q <= ie_q & summary;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_req_q <= 1'b0;
    end else begin
      wake_req_q <= sleep_active & ie_q & summary;
    end
  end

  // Pad drive: latch data, direction gates the driver regardless of analog mode
  genvar p;
  generate
    for (p = 0; p < W; p++) begin : g_pad
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pad_out_q[p] <= 1'b0;
          pad_oe_q[p]  <= 1'b0;
        end else if (odrain_q[p]) begin
          pad_out_q[p] <= 1'b0;
          pad_oe_q[p]  <= ~dir_q[p] & ~latch_q[p];
        end else begin
          pad_out_q[p] <= latch_q[p];
          pad_oe_q[p]  <= ~dir_q[p];
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_slew_q   <= GPC_RST_SLEW;
      pad_pullup_q <= GPC_RST_PULLUP;
      pad_analog_q <= GPC_RST_ANALOG;
    end else begin
      pad_slew_q   <= slew_q;
      pad_pullup_q <= pullup_q;
      pad_analog_q <= analog_q;
    end
  end

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign pad_out    = pad_out_q;
  assign pad_oe     = pad_oe_q;
  assign pad_slew   = pad_slew_q;
  assign pad_pullup = pad_pullup_q;
  assign pad_analog = pad_analog_q;
  assign change_irq = change_irq_q;
  assign wake_req   = wake_req_q;

endmodule
`default_nettype wire

/* File: gpc_pkg.sv */
// Constants, register map and reset values for the GPIO port with change detection
// Functional notes
// - Direction 1 floats driver, 0 drives latch
// - Port read gives pins, write loads latch
// - Port write is read-modify-write of pins
// - Direction still governs driver on analog pins
// - Per-pin Schmitt or TTL input threshold select
// - Open-drain bit makes output sink only
// - Slew bit limits drive slew rate
// - Analog select makes digital reads zero
// - Analog select leaves digital output untouched
// - Analog select bits reset to analog mode
// - Pins float as inputs after reset
// - Per-pin rising and falling detectors, each enabled
// - Both enables set detect both edge directions
// - Master enable clear still sets flags, no irq
// - Enabled edge sets flag, irq if enabled
// - Summary flag is OR of pin flags
// - Writing zero clears flag, new edge wins
// - Enabled change interrupt wakes device from sleep
// - Sleep edge flag set before wake request
// - Threshold bit 1 Schmitt, 0 TTL
package gpc_pkg;

  localparam int          GPC_PINS          = 8;
  localparam int          GPC_AW            = 12;

  localparam logic [11:0] GPC_OFS_PIN       = 12'h000;
  localparam logic [11:0] GPC_OFS_LATCH     = 12'h004;
  localparam logic [11:0] GPC_OFS_DIR       = 12'h008;
  localparam logic [11:0] GPC_OFS_ANALOG    = 12'h00C;
  localparam logic [11:0] GPC_OFS_INLVL     = 12'h010;
  localparam logic [11:0] GPC_OFS_ODRAIN    = 12'h014;
  localparam logic [11:0] GPC_OFS_SLEW      = 12'h018;
  localparam logic [11:0] GPC_OFS_PULLUP    = 12'h01C;
  localparam logic [11:0] GPC_OFS_RISE      = 12'h020;
  localparam logic [11:0] GPC_OFS_FALL      = 12'h024;
  localparam logic [11:0] GPC_OFS_FLAG      = 12'h028;
  localparam logic [11:0] GPC_OFS_ICTRL     = 12'h02C;

  localparam logic [7:0]  GPC_RST_LATCH     = 8'h00;
  localparam logic [7:0]  GPC_RST_DIR       = 8'hFF;
  localparam logic [7:0]  GPC_RST_ANALOG    = 8'hFF;
  localparam logic [7:0]  GPC_RST_INLVL     = 8'h00;
  localparam logic [7:0]  GPC_RST_ODRAIN    = 8'h00;
  localparam logic [7:0]  GPC_RST_SLEW      = 8'hFF;
  localparam logic [7:0]  GPC_RST_PULLUP    = 8'h00;
  localparam logic [7:0]  GPC_RST_RISE      = 8'h00;
  localparam logic [7:0]  GPC_RST_FALL      = 8'h00;
  localparam logic [7:0]  GPC_RST_FLAG      = 8'h00;
  localparam logic        GPC_RST_IE        = 1'b0;

  localparam int          GPC_ICTRL_IE_BIT  = 0;
  localparam int          GPC_ICTRL_IF_BIT  = 1;
  localparam int          GPC_WMASK_LSB     = 8;

endpackage

/* File: gpc_sense_if.sv */
// Interface between register logic and the per-pin input sense logic
`timescale 1ns/100ps
`default_nettype none
interface gpc_sense_if #(
  parameter int W = 8
);
  logic [W-1:0] thr_sel;
  logic [W-1:0] analog;
  logic [W-1:0] rise_en;
  logic [W-1:0] fall_en;
  logic [W-1:0] level;
  logic [W-1:0] rise_evt;
  logic [W-1:0] fall_evt;

  modport ctrl  (output thr_sel, output analog, output rise_en, output fall_en,
                 input level, input rise_evt, input fall_evt);
  modport sense (input thr_sel, input analog, input rise_en, input fall_en,
                 output level, output rise_evt, output fall_evt);
endinterface
`default_nettype wire

/* File: gpc_pin_sense.sv */
// Per-pin input synchroniser, threshold select, analog mask and edge detectors
`timescale 1ns/100ps
`default_nettype none
module gpc_pin_sense
  import gpc_pkg::*;
#(
  parameter int W = GPC_PINS
) (
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire logic [W-1:0] pin_st,
  input  wire logic [W-1:0] pin_ttl,
  gpc_sense_if.sense     sn
);

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_pin
      logic st_s1_q;
      logic st_s2_q;
      logic ttl_s1_q;
      logic ttl_s2_q;
      logic lvl_q;
      logic prev_q;
      logic lvl_d;

      // Two-flop synchronisers on both comparator outputs
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          st_s1_q  <= 1'b0;
          st_s2_q  <= 1'b0;
          ttl_s1_q <= 1'b0;
          ttl_s2_q <= 1'b0;
        end else begin
          st_s1_q  <= pin_st[g];
          st_s2_q  <= st_s1_q;
          ttl_s1_q <= pin_ttl[g];
          ttl_s2_q <= ttl_s1_q;
        end
      end

      // Threshold choice, then analog pins read as zero
      always_comb begin
        lvl_d = sn.thr_sel[g] ? st_s2_q : ttl_s2_q;
        if (sn.analog[g]) begin
          lvl_d = 1'b0;
        end
      end

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          lvl_q  <= 1'b0;
          prev_q <= 1'b0;
        end else begin
          lvl_q  <= lvl_d;
          prev_q <= lvl_q;
        end
      end

      assign sn.level[g]    = lvl_q;
      assign sn.rise_evt[g] = sn.rise_en[g] & lvl_q & ~prev_q;
      assign sn.fall_evt[g] = sn.fall_en[g] & ~lvl_q & prev_q;
    end
  endgenerate

endmodule
`default_nettype wire

/* File: gpc_pad_model.sv */
// Pad model: external drivers, pull-ups and threshold comparators
`timescale 1ns/100ps
`default_nettype none
module gpc_pad_model
  import gpc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pad_pullup,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ttl_skew,
  output logic      [7:0] pad_st_in,
  output logic      [7:0] pad_ttl_in
);
  logic [7:0] flt_q = 8'h00;
  logic [7:0] lvl;
  // Undriven pins without pull-up toggle every cycle
  always_ff @(posedge clk) begin
    flt_q <= ~lvl;
  end
  assign lvl = (pad_oe & pad_out) | (~pad_oe & ((ext_en & ext_val) |
               (~ext_en & (pad_pullup | flt_q))));
  assign pad_st_in  = lvl;
  assign pad_ttl_in = lvl ^ ttl_skew;
endmodule
`default_nettype wire

/* File: gpc_port_checker.sv */
// Assertion checker bound to the GPIO port top
`timescale 1ns/100ps
`default_nettype none
module gpc_port_checker
  import gpc_pkg::*;
#(
  parameter int W  = GPC_PINS,
  parameter int AW = GPC_AW
) (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [3:0]    pstrb,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic [W-1:0]  pad_oe,
  input wire logic [W-1:0]  pad_slew,
  input wire logic [W-1:0]  pad_analog,
  input wire logic          sleep_active,
  input wire logic          change_irq,
  input wire logic          wake_req
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc;
    psel && penable && pready;
  endsequence
  sequence s_wr(logic [AW-1:0] a);
    s_acc ##0 pwrite && pstrb[0] && paddr == a;
  endsequence
  sequence s_rd(logic [AW-1:0] a);
    s_acc ##0 !pwrite && paddr == a;
  endsequence
  property p_ready;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("ready timing");
  property p_err;
    s_acc ##0 !pwrite && pslverr |-> prdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("unmapped read data");
  property p_dir;
    s_wr(GPC_OFS_DIR) |-> ##2 (pad_oe & $past(pwdata[W-1:0], 2)) == '0;
  endproperty
  a_dir: assert property (p_dir) else $error("input pin driven");
  property p_slew;
    s_wr(GPC_OFS_SLEW) |-> ##2 pad_slew == $past(pwdata[W-1:0], 2);
  endproperty
  a_slew: assert property (p_slew) else $error("slew output");
  property p_rst;
    $rose(presetn) |-> pad_analog == GPC_RST_ANALOG && pad_oe == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset pad state");
  property p_pin_ana;
    s_rd(GPC_OFS_PIN) |-> (prdata[W-1:0] & pad_analog & $past(pad_analog, 2)) == '0;
  endproperty
  a_pin_ana: assert property (p_pin_ana) else $error("analog pin read");
  property p_ie_off;
    s_wr(GPC_OFS_ICTRL) ##0 !pwdata[GPC_ICTRL_IE_BIT] |-> ##2 !change_irq;
  endproperty
  a_ie_off: assert property (p_ie_off) else $error("irq while disabled");
  property p_irq_sum;
    s_rd(GPC_OFS_ICTRL) |-> change_irq == (prdata[GPC_ICTRL_IE_BIT] && prdata[GPC_ICTRL_IF_BIT]);
  endproperty
  a_irq_sum: assert property (p_irq_sum) else $error("irq vs summary");
  property p_wake;
    wake_req == ($past(sleep_active) && change_irq);
  endproperty
  a_wake: assert property (p_wake) else $error("wake request");
endmodule
bind gpc_port gpc_port_checker #(.W(W), .AW(AW)) u_gpc_port_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pad_oe(pad_oe), .pad_slew(pad_slew), .pad_analog(pad_analog),
  .sleep_active(sleep_active), .change_irq(change_irq), .wake_req(wake_req));
`default_nettype wire

/* File: gpc_port_tb.sv */
// Testbench for the GPIO port with change detection
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module gpc_port_tb
  import gpc_pkg::*;
;
  typedef struct {string n; logic [32:0] v;} gpc_exp_t;
  logic        pclk, presetn, psel, penable, pwrite, sleep_active;
  logic        pready, pslverr, change_irq, wake_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [7:0]  pad_st_in, pad_ttl_in, pad_out, pad_oe, pad_slew, pad_pullup;
  logic [7:0]  pad_analog, ext_val, ext_en, v, p;
  int          errors, cmp_count, seed;
  gpc_exp_t    expq[$];
  logic [7:0]  rv[12] = '{8'h00, GPC_RST_LATCH, GPC_RST_DIR, GPC_RST_ANALOG,
    GPC_RST_INLVL, GPC_RST_ODRAIN, GPC_RST_SLEW, GPC_RST_PULLUP, GPC_RST_RISE,
    GPC_RST_FALL, GPC_RST_FLAG, 8'h00};
  gpc_port u_gpc_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pad_st_in(pad_st_in), .pad_ttl_in(pad_ttl_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_slew(pad_slew), .pad_pullup(pad_pullup),
    .pad_analog(pad_analog), .sleep_active(sleep_active), .change_irq(change_irq),
    .wake_req(wake_req));
  gpc_pad_model u_gpc_pad_model (.clk(pclk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pullup), .ext_val(ext_val), .ext_en(ext_en), .ttl_skew(8'h3C),
    .pad_st_in(pad_st_in), .pad_ttl_in(pad_ttl_in));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, 4'h1);
  endtask
  task automatic rd(input string n, input logic [11:0] a, input logic [7:0] e);
    expq.push_back('{n, {25'h0, e}});
    apb(1'b0, a, 32'h0, 4'h0);
  endtask
  task automatic test_done;
    $display("Compares %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Read results are compared in bus order
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      `CHK(expq[0].n, expq[0].v, {pslverr, prdata})
      void'(expq.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    test_done();
  end
  initial begin
    seed = 32'h97e6b864;
    {presetn, psel, penable, pwrite, sleep_active} = 5'h00;
    {paddr, pwdata, pstrb} = 48'h0;
    ext_val = 8'h00;
    ext_en = 8'hFF;
    cyc(4);
    presetn <= 1'b1;
    for (int i = 0; i < 12; i++) rd("reset", GPC_OFS_PIN + 12'(4 * i), rv[i]);
    expq.push_back('{"unmapped", {1'b1, 32'h0}});
    apb(1'b0, 12'h030, 32'h0, 4'h0);
    for (int i = 1; i < 10; i++) begin
      v = 8'($random(seed));
      wr(GPC_OFS_PIN + 12'(4 * i), v);
      rd("rw", GPC_OFS_PIN + 12'(4 * i), v);
    end
    $display("test registers done");
    wr(GPC_OFS_RISE, 8'h00);
    wr(GPC_OFS_FALL, 8'h00);
    wr(GPC_OFS_ANALOG, 8'h00);
    wr(GPC_OFS_DIR, 8'hFF);
    wr(GPC_OFS_ODRAIN, 8'h00);
    wr(GPC_OFS_INLVL, 8'h00);
    ext_val <= 8'($random(seed));
    cyc(6);
    rd("pin_ttl", GPC_OFS_PIN, ext_val ^ 8'h3C);
    wr(GPC_OFS_INLVL, 8'hFF);
    cyc(6);
    rd("pin_st", GPC_OFS_PIN, ext_val);
    wr(GPC_OFS_PULLUP, 8'hFF);
    ext_en <= 8'h00;
    cyc(6);
    rd("pullup", GPC_OFS_PIN, 8'hFF);
    ext_en <= 8'hFF;
    wr(GPC_OFS_ANALOG, 8'h0F);
    cyc(6);
    rd("pin_ana", GPC_OFS_PIN, ext_val & 8'hF0);
    wr(GPC_OFS_ANALOG, 8'hFF);
    wr(GPC_OFS_LATCH, 8'hA5);
    wr(GPC_OFS_DIR, 8'h00);
    cyc(2);
    `CHK("drive", 16'hA5FF, {pad_out, pad_oe})
    wr(GPC_OFS_ODRAIN, 8'hFF);
    cyc(2);
    `CHK("odrain", 16'h005A, {pad_out, pad_oe})
    wr(GPC_OFS_ODRAIN, 8'h00);
    wr(GPC_OFS_ANALOG, 8'h00);
    wr(GPC_OFS_DIR, 8'hF0);
    cyc(6);
    p = {ext_val[7:4], 4'h5};
    rd("pin_mix", GPC_OFS_PIN, p);
    apb(1'b1, GPC_OFS_PIN, {16'h0, 8'h33, 8'hCA}, 4'h3);
    apb(1'b1, GPC_OFS_LATCH, 32'hFF, 4'h0);
    rd("rmw", GPC_OFS_LATCH, (p & 8'hCC) | 8'h02);
    $display("test pins done");
    wr(GPC_OFS_DIR, 8'hFF);
    ext_val <= 8'h00;
    wr(GPC_OFS_RISE, 8'h05);
    wr(GPC_OFS_FALL, 8'h06);
    cyc(6);
    wr(GPC_OFS_FLAG, 8'h00);
    ext_val <= 8'h07;
    cyc(6);
    rd("rise", GPC_OFS_FLAG, 8'h05);
    ext_val <= 8'h00;
    cyc(6);
    rd("both", GPC_OFS_FLAG, 8'h07);
    rd("summary", GPC_OFS_ICTRL, 8'h02);
    `CHK("irq_off", 1'b0, change_irq)
    wr(GPC_OFS_FLAG, 8'h07 ^ 8'h05);
    rd("and_clr", GPC_OFS_FLAG, 8'h02);
    wr(GPC_OFS_ICTRL, 8'h01);
    cyc(2);
    `CHK("irq_on", 1'b1, change_irq)
    sleep_active <= 1'b1;
    cyc(2);
    `CHK("wake", 1'b1, wake_req)
    wr(GPC_OFS_FLAG, 8'h00);
    cyc(2);
    `CHK("irq_clr", 2'b00, {change_irq, wake_req})
    ext_val <= 8'h01;
    for (int k = 0; k < 20 && wake_req !== 1'b1; k++) @(posedge pclk);
    rd("sleep", GPC_OFS_FLAG, 8'h01);
    sleep_active <= 1'b0;
    wr(GPC_OFS_ICTRL, 8'h00);
    for (int d = 0; d < 2; d++) begin
      ext_val <= ext_val ^ 8'h04;
      cyc(d);
      wr(GPC_OFS_FLAG, 8'h00);
      rd("race", GPC_OFS_FLAG, 8'h04);
      wr(GPC_OFS_FLAG, 8'h00);
    end
    $display("test change done");
    cyc(1);
    test_done();
  end
endmodule
`default_nettype wire
